// *** design/timer_defines.svh ***
// Constants for the 16-bit timer with waveform extensions.
// Included by the package only; the design modules use its macros. Holds definitions only.
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

// =====================================================================
// Widths and channel counts
`define COUNT_W        16
`define CH_MAX         4
`define TYPE0_CH       4
`define TYPE1_CH       2
`define PIN_N          8
`define DT_W           8
`define PRESC_W        10

// =====================================================================
// Reset values
`define COUNT_RESET    16'h0000
`define PERIOD_RESET   16'hffff
`define CC_RESET       16'h0000
`define PATTERN_RESET  8'h00
`define DT_RESET       8'h00

// =====================================================================
// Timing: fast clock runs four times the base clock
`define BASE_DIV_LAST  2'h3
`define NC_HIST_W      3

// =====================================================================
// Prescaler masks: tick when the masked prescaler bits are all ones
`define PRESC_M1       10'h000
`define PRESC_M2       10'h001
`define PRESC_M4       10'h003
`define PRESC_M8       10'h007
`define PRESC_M64      10'h03f
`define PRESC_M256     10'h0ff
`define PRESC_M1024    10'h3ff

`endif

// *** design/timer_pkg.sv ***
// Types shared by the timer core and its helper modules.
// Assumes timer_defines.svh is on the include path.
`include "timer_defines.svh"

package timer_pkg;

   // ==================================================================
   // Mode enumerations and value types
   typedef enum logic [1:0] {WM_NORMAL, WM_FREQ, WM_SINGLE, WM_DUAL} wave_mode_t;
   typedef enum logic [1:0] {CS_OFF, CS_CLOCK, CS_EVENT, CS_EXT} clk_src_t;
   typedef enum logic [1:0] {CAP_INPUT, CAP_FREQ, CAP_PULSE, CAP_NONE} cap_mode_t;
   typedef logic [`COUNT_W-1:0] count_t;
   typedef logic [`DT_W-1:0]    dt_t;

endpackage

// *** design/noise_canceller.sv ***
// Capture input filter: output follows the input only after four equal
// samples. Assumes the input is synchronous to clk_i.
`timescale 1ns/1ns

module noise_canceller
   import timer_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic reset_i,
   input  wire logic enable_i,
   input  wire logic raw_i,
   output logic      filt_o
);

   typedef struct packed {
      logic [`NC_HIST_W-1:0] hist;
      logic                  filt;
   } nc_state_t;

   nc_state_t state_reg;
   nc_state_t state_next;

   // ==================================================================
   // Filter
   always_comb begin
      state_next      = state_reg;
      state_next.hist = {state_reg.hist[`NC_HIST_W-2:0], raw_i};
      if (!enable_i) begin
         state_next.filt = raw_i;
      end else if (&{state_reg.hist, raw_i}) begin
         state_next.filt = 1'b1;
      end else if (~|{state_reg.hist, raw_i}) begin
         state_next.filt = 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign filt_o = state_reg.filt;

endmodule // noise_canceller

// *** design/dead_time_inserter.sv ***
// One dead-time unit: splits a waveform into low and high side outputs
// with programmable gaps. Counts in ticks of the timer clock.
`timescale 1ns/1ns

module dead_time_inserter
   import timer_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic reset_i,
   input  wire logic enable_i,
   input  wire logic tick_i,
   input  wire logic wave_i,
   input  wire dt_t  dt_ls_i,
   input  wire dt_t  dt_hs_i,
   output logic      low_side_o,
   output logic      high_side_o
);

   typedef struct packed {
      logic ls;
      logic hs;
      logic prev;
      dt_t  cnt;
   } dti_state_t;

   dti_state_t state_reg;
   dti_state_t state_next;

   // ==================================================================
   // Gap sequencing
   always_comb begin
      state_next      = state_reg;
      state_next.prev = wave_i;
      if (!enable_i) begin
         state_next.ls  = wave_i;
         state_next.hs  = !wave_i;
         state_next.cnt = `DT_RESET;
      end else if (wave_i != state_reg.prev) begin
         state_next.ls  = 1'b0;
         state_next.hs  = 1'b0;
         state_next.cnt = wave_i ? dt_ls_i : dt_hs_i;
      end else if (state_reg.cnt != `DT_RESET) begin
         if (tick_i) begin
            state_next.cnt = state_reg.cnt - 8'h01;
         end
      end else begin
         state_next.ls = wave_i;
         state_next.hs = !wave_i;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign low_side_o  = state_reg.ls;
   assign high_side_o = state_reg.hs;

endmodule // dead_time_inserter

// *** design/timer_with_waveform_extensions.sv ***
// 16-bit timer/counter with compare/capture channels, resolution
// extension and advanced waveform extension driving one 8-pin port.
// Assumes clk_i is the fast clock; events arrive as synchronous levels.
`timescale 1ns/1ns

module timer_with_waveform_extensions
   import timer_pkg::*;
#(
   parameter int TIMER_TYPE = 0
)(
   input  wire logic                  clk_i,
   input  wire logic                  reset_i,
   input  wire logic                  enable_i,
   input  wire clk_src_t              clk_src_i,
   input  wire logic [2:0]            presc_sel_i,
   input  wire logic [7:0]            event_i,
   input  wire logic [2:0]            count_event_sel_i,
   input  wire logic                  ext_count_i,
   input  wire logic                  dir_event_en_i,
   input  wire logic [2:0]            dir_event_sel_i,
   input  wire wave_mode_t            wave_mode_i,
   input  wire logic                  hires_en_i,
   input  wire count_t                period_buf_i,
   input  wire logic                  period_wr_i,
   input  wire count_t                cmp_buf_i,
   input  wire logic [3:0]            cmp_wr_i,
   input  wire logic [3:0]            capture_en_i,
   input  wire logic [3:0][2:0]       capture_sel_i,
   input  wire cap_mode_t             capture_mode_i,
   input  wire logic                  noise_cancel_en_i,
   input  wire logic                  dti_en_i,
   input  wire dt_t                   dt_ls_buf_i,
   input  wire dt_t                   dt_hs_buf_i,
   input  wire logic [3:0]            dt_wr_i,
   input  wire logic                  pattern_en_i,
   input  wire logic [7:0]            pattern_buf_i,
   input  wire logic                  pattern_wr_i,
   input  wire logic [7:0]            override_en_i,
   input  wire logic [7:0]            port_out_i,
   input  wire logic [7:0]            pin_invert_i,
   input  wire logic [7:0]            fault_event_mask_i,
   input  wire logic                  fault_clear_i,
   output count_t                     count_o,
   output logic                       count_down_o,
   output logic [3:0][`COUNT_W-1:0]   cc_value_o,
   output logic                       overflow_o,
   output logic [3:0]                 cc_event_o,
   output logic [3:0]                 wave_o,
   output logic                       fault_o,
   output logic [7:0]                 pin_o
);

   localparam int NUM_CH = (TIMER_TYPE == 0) ? `TYPE0_CH : `TYPE1_CH;
   localparam logic EXT_OK = (TIMER_TYPE == 0);

   typedef struct packed {
      count_t                      count;
      logic                        dir;
      logic [1:0]                  base_div;
      logic [`PRESC_W-1:0]         presc;
      logic                        cnt_ev_prev;
      logic                        ext_prev;
      count_t                      period;
      count_t                      period_buf;
      logic                        period_bv;
      logic [3:0][`COUNT_W-1:0]    cc;
      logic [3:0][`COUNT_W-1:0]    cc_buf;
      logic [3:0]                  cc_bv;
      logic [3:0]                  wave;
      logic [3:0]                  cap_prev;
      logic [3:0][`DT_W-1:0]       dt_ls;
      logic [3:0][`DT_W-1:0]       dt_hs;
      logic [3:0][`DT_W-1:0]       dt_ls_buf;
      logic [3:0][`DT_W-1:0]       dt_hs_buf;
      logic [3:0]                  dt_bv;
      logic [7:0]                  pattern;
      logic [7:0]                  pattern_buf;
      logic                        pattern_bv;
      logic                        ovf;
      logic [3:0]                  cc_ev;
      logic                        fault;
      logic [7:0]                  pin;
   } timer_state_t;

   timer_state_t state_reg;
   timer_state_t state_next;

   logic                base_tick;
   logic [`PRESC_W-1:0] presc_mask;
   logic                count_tick;
   logic [3:0]          cap_filt;
   logic [3:0]          ls_out;
   logic [3:0]          hs_out;
   logic                ext_active;

   // ==================================================================
   // Clock selection
   // fast clock when extension on
   assign base_tick = hires_en_i | (state_reg.base_div == `BASE_DIV_LAST);

   always_comb begin
      unique case (presc_sel_i)
         3'h0:    presc_mask = `PRESC_M1;
         3'h1:    presc_mask = `PRESC_M2;
         3'h2:    presc_mask = `PRESC_M4;
         3'h3:    presc_mask = `PRESC_M8;
         3'h4:    presc_mask = `PRESC_M64;
         3'h5:    presc_mask = `PRESC_M256;
         default: presc_mask = `PRESC_M1024;
      endcase
   end

   always_comb begin
      unique case (clk_src_i)
         CS_OFF:   count_tick = 1'b0;
         CS_CLOCK: count_tick = base_tick && ((state_reg.presc & presc_mask) == presc_mask);
         CS_EVENT: count_tick = event_i[count_event_sel_i] && !state_reg.cnt_ev_prev;
         CS_EXT:   count_tick = ext_count_i && !state_reg.ext_prev;
      endcase
      count_tick = count_tick && enable_i;
   end

   // pair split or pattern active on type 0 when either feature is on
   assign ext_active = EXT_OK && (dti_en_i || pattern_en_i);

   // ==================================================================
   // Per-channel capture filters and dead-time units
   genvar g;
   generate
      for (g = 0; g < `CH_MAX; g++) begin : g_ch
         noise_canceller u_nc (
            .clk_i    (clk_i),
            .reset_i  (reset_i),
            .enable_i (noise_cancel_en_i),
            .raw_i    (event_i[capture_sel_i[g]]),
            .filt_o   (cap_filt[g])
         );
         dead_time_inserter u_dti (
            .clk_i       (clk_i),
            .reset_i     (reset_i),
            .enable_i    (EXT_OK && dti_en_i && !pattern_en_i),
            .tick_i      (base_tick),
            .wave_i      (state_reg.wave[g]),
            .dt_ls_i     (state_reg.dt_ls[g]),
            .dt_hs_i     (state_reg.dt_hs[g]),
            .low_side_o  (ls_out[g]),
            .high_side_o (hs_out[g])
         );
      end
   endgenerate

   // ==================================================================
   // Next state
   always_comb begin
      count_t top;
      logic   down;
      logic   update;
      logic   pv;
      top              = (wave_mode_i == WM_FREQ) ? state_reg.cc[0] : state_reg.period;
      down             = dir_event_en_i && event_i[dir_event_sel_i];
      update           = !enable_i || (clk_src_i == CS_OFF);
      pv               = 1'b0;
      state_next       = state_reg;
      state_next.ovf   = 1'b0;
      state_next.cc_ev = '0;
      state_next.base_div    = state_reg.base_div + 2'h1;
      state_next.cnt_ev_prev = event_i[count_event_sel_i];
      state_next.ext_prev    = ext_count_i;
      state_next.cap_prev    = cap_filt;
      if (base_tick) begin
         state_next.presc = state_reg.presc + 10'h001;
      end

      // Counter; dual slope turns at top and updates at bottom
      if (count_tick) begin
         if (wave_mode_i == WM_DUAL) begin
            if (!state_reg.dir) begin
               if (state_reg.count >= top) begin
                  state_next.dir   = 1'b1;
                  state_next.count = state_reg.count - 16'h0001;
               end else begin
                  state_next.count = state_reg.count + 16'h0001;
               end
            end else if (state_reg.count == `COUNT_RESET) begin
               state_next.dir   = 1'b0;
               state_next.count = 16'h0001;
               state_next.ovf   = 1'b1;
               update           = 1'b1;
            end else begin
               state_next.count = state_reg.count - 16'h0001;
            end
         end else if (down) begin
            state_next.dir = 1'b1;
            if (state_reg.count == `COUNT_RESET) begin
               state_next.count = top;
               state_next.ovf   = 1'b1;
               update           = 1'b1;
            end else begin
               state_next.count = state_reg.count - 16'h0001;
            end
         end else begin
            state_next.dir = 1'b0;
            if (state_reg.count >= top) begin
               state_next.count = `COUNT_RESET;
               state_next.ovf   = 1'b1;
               update           = 1'b1;
               if (wave_mode_i == WM_FREQ) begin
                  state_next.wave[0] = !state_reg.wave[0];
               end
            end else begin
               state_next.count = state_reg.count + 16'h0001;
            end
         end
      end

      if (update && state_reg.period_bv) begin
         state_next.period    = state_reg.period_buf;
         state_next.period_bv = 1'b0;
      end
      if (period_wr_i) begin
         state_next.period_buf = period_buf_i;
         state_next.period_bv  = 1'b1;
      end
      if (update && state_reg.pattern_bv) begin
         state_next.pattern    = state_reg.pattern_buf;
         state_next.pattern_bv = 1'b0;
      end
      if (pattern_wr_i) begin
         state_next.pattern_buf = pattern_buf_i;
         state_next.pattern_bv  = 1'b1;
      end

      for (int k = 0; k < NUM_CH; k++) begin
         if (update && state_reg.cc_bv[k] && !capture_en_i[k]) begin
            state_next.cc[k]    = state_reg.cc_buf[k];
            state_next.cc_bv[k] = 1'b0;
         end
         if (cmp_wr_i[k]) begin
            state_next.cc_buf[k] = cmp_buf_i;
            state_next.cc_bv[k]  = 1'b1;
         end
         if (update && state_reg.dt_bv[k]) begin
            state_next.dt_ls[k] = state_reg.dt_ls_buf[k];
            state_next.dt_hs[k] = state_reg.dt_hs_buf[k];
            state_next.dt_bv[k] = 1'b0;
         end
         if (dt_wr_i[k]) begin
            state_next.dt_ls_buf[k] = dt_ls_buf_i;
            state_next.dt_hs_buf[k] = dt_hs_buf_i;
            state_next.dt_bv[k]     = 1'b1;
         end
         if (!capture_en_i[k]) begin
            if (count_tick && state_reg.count == state_reg.cc[k]) begin
               state_next.cc_ev[k] = 1'b1;
            end
            if (wave_mode_i == WM_SINGLE || wave_mode_i == WM_DUAL) begin
               state_next.wave[k] = state_reg.count < state_reg.cc[k];
            end
         end else if (cap_filt[k] != state_reg.cap_prev[k]) begin
            unique case (capture_mode_i)
               CAP_INPUT: if (cap_filt[k]) begin
                  state_next.cc[k]    = state_reg.count;
                  state_next.cc_ev[k] = 1'b1;
               end
               CAP_FREQ: if (cap_filt[k]) begin
                  state_next.cc[k]    = state_reg.count;
                  state_next.cc_ev[k] = 1'b1;
                  state_next.count    = `COUNT_RESET;
               end
               CAP_PULSE: if (cap_filt[k]) begin
                  state_next.count = `COUNT_RESET;
               end else begin
                  state_next.cc[k]    = state_reg.count;
                  state_next.cc_ev[k] = 1'b1;
               end
               CAP_NONE: ;
            endcase
         end
      end

      state_next.fault = (|(event_i & fault_event_mask_i))
                       || (state_reg.fault && !fault_clear_i);

      // Port mux
      for (int i = 0; i < `PIN_N; i++) begin
         pv = port_out_i[i];
         if (override_en_i[i]) begin
            if (EXT_OK && pattern_en_i) begin
               pv = state_reg.pattern[i] && state_reg.wave[0];
            end else if (ext_active) begin
               pv = i[0] ? hs_out[i/2] : ls_out[i/2];
            end else if (i < NUM_CH) begin
               pv = state_reg.wave[i];
            end
            // Fault forces the switches off rather than freezing them
            if (ext_active && state_reg.fault) begin
               pv = 1'b0;
            end
         end
         state_next.pin[i] = pv ^ pin_invert_i[i];
      end
   end

   // ==================================================================
   // State register
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_reg        <= '0;
         state_reg.period <= `PERIOD_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   assign count_o      = state_reg.count;
   assign count_down_o = state_reg.dir;
   assign cc_value_o   = state_reg.cc;
   assign overflow_o   = state_reg.ovf;
   assign cc_event_o   = state_reg.cc_ev;
   assign wave_o       = state_reg.wave;
   assign fault_o      = state_reg.fault;
   assign pin_o        = state_reg.pin;

endmodule // timer_with_waveform_extensions

// *** testbench/timer_checks_asserts.sv ***
// Checker for the timer: counting, wrap, fault and half-bridge pin relations.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns
module timer_checks
   import timer_pkg::*;
(
   input wire logic       clk_i,
   input wire logic       reset_i,
   input wire logic       enable_i,
   input wire clk_src_t   clk_src_i,
   input wire logic [2:0] presc_sel_i,
   input wire logic [7:0] event_i,
   input wire logic       dir_event_en_i,
   input wire logic [2:0] dir_event_sel_i,
   input wire wave_mode_t wave_mode_i,
   input wire logic       hires_en_i,
   input wire logic [3:0] capture_en_i,
   input wire logic       dti_en_i,
   input wire logic       pattern_en_i,
   input wire logic [7:0] override_en_i,
   input wire logic [7:0] pin_invert_i,
   input wire logic [7:0] fault_event_mask_i,
   input wire logic       fault_clear_i,
   input wire count_t     count_o,
   input wire logic       count_down_o,
   input wire logic       overflow_o,
   input wire logic       fault_o,
   input wire logic [7:0] pin_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);
   // ============================================================
   // Qualifiers: single-slope, one tick per clock, no capture; dead-time pair on pins 0 and 1
   logic fast;
   logic run;
   logic pair;
   assign fast = enable_i && clk_src_i == CS_CLOCK && presc_sel_i == 3'h0 && hires_en_i
      && capture_en_i == 4'h0 && wave_mode_i == WM_SINGLE;
   assign run = fast && !dir_event_en_i;
   assign pair = dti_en_i && !pattern_en_i && override_en_i[1:0] == 2'h3
      && pin_invert_i[1:0] == 2'h0;
   // ============================================================
   // Assertions
   AST_CNT_HOLD: assert property (!enable_i && capture_en_i == 4'h0 |=> $stable(count_o))
      else $error("count moved while stopped");
   AST_CNT_STEP: assert property (
      run |=> count_o == $past(count_o) + 16'h1 || count_o == 16'h0)
      else $error("count skipped a value");
   AST_OVF_WRAP: assert property (
      run && count_o != 16'h0 ##1 count_o == 16'h0 |-> ##[0:1] overflow_o)
      else $error("wrap without overflow");
   AST_DIR_DOWN: assert property (
      (fast && dir_event_en_i && event_i[dir_event_sel_i])[*3] |-> count_down_o)
      else $error("direction event ignored");
   AST_FLT_SET: assert property (|(event_i & fault_event_mask_i) |=> fault_o)
      else $error("fault not raised");
   AST_FLT_HOLD: assert property (fault_o && !fault_clear_i |=> fault_o)
      else $error("fault dropped without clear");
   AST_FLT_PINS: assert property (
      (fault_o && dti_en_i && $stable(pin_invert_i) && $stable(override_en_i))[*5]
      |-> ((pin_o ^ pin_invert_i) & override_en_i) == 8'h00)
      else $error("pin driven during fault");
   AST_DTI_GAP: assert property (pair [*5] |-> !(pin_o[0] && pin_o[1]))
      else $error("both sides on");
   CV_WRAP: cover property (run && overflow_o);
   CV_FAULT: cover property ($rose(fault_o));
   CV_DOWN: cover property (count_down_o);
endmodule // timer_checks

bind timer_with_waveform_extensions timer_checks chk (.*);

// *** testbench/half_bridge_load.sv ***
// Load on the port pins: one half bridge switched by pins 0 and 1.
// Assumes the pin invert setting is known to the board, as in practice.
`timescale 1ns/1ns
module half_bridge_load (
   input  wire logic       clk_i,
   input  wire logic       reset_i,
   input  wire logic [7:0] pin_i,
   input  wire logic [7:0] invert_i,
   output logic            shoot_o
);
   // ============================================================
   // Shoot-through latch: both switches on would short the supply
   logic [7:0] level;
   assign level = pin_i ^ invert_i;
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         shoot_o <= 1'b0;
      end else if (level[0] && level[1]) begin
         shoot_o <= 1'b1;
      end
   end
endmodule // half_bridge_load

// *** testbench/timer_with_waveform_extensions_tb.sv ***
// Bench for the timer: sources, waveforms, buffering, capture, dead time,
// fault and pattern. Assumes the load model and the bound checker.
`timescale 1ns/1ns
module timer_with_waveform_extensions_tb
   import timer_pkg::*;
;
   logic             clk_i, reset_i, enable_i, ext_count_i, dir_event_en_i, hires_en_i;
   logic             period_wr_i, noise_cancel_en_i, dti_en_i, pattern_en_i, pattern_wr_i;
   logic             fault_clear_i, count_down_o, overflow_o, fault_o, shoot, both;
   logic [2:0]       presc_sel_i, count_event_sel_i, dir_event_sel_i;
   logic [3:0]       cmp_wr_i, capture_en_i, dt_wr_i, cc_event_o, wave_o, wev;
   logic [7:0]       event_i, pattern_buf_i, override_en_i, port_out_i, pin_invert_i;
   logic [7:0]       fault_event_mask_i, pin_o, pin_or;
   logic [3:0][2:0]  capture_sel_i;
   logic [3:0][15:0] cc_value_o;
   dt_t              dt_ls_buf_i, dt_hs_buf_i;
   count_t           period_buf_i, cmp_buf_i, count_o, cmax, c0;
   clk_src_t         clk_src_i;
   wave_mode_t       wave_mode_i;
   cap_mode_t        capture_mode_i;
   int               n_errors = 0, n_tests = 0, ovf_n, w1;

   timer_with_waveform_extensions #(.TIMER_TYPE(0)) uut (.*);
   half_bridge_load load (.clk_i(clk_i), .reset_i(reset_i), .pin_i(pin_o),
      .invert_i(pin_invert_i), .shoot_o(shoot));

   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   // ============================================================
   // Shared tasks
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Watch the outputs for n cycles, sampled at falling edges
   task automatic obs(input int n);
      {pin_or, both, wev, cmax} = '0;
      ovf_n = 0;
      w1 = 0;
      repeat (n) begin
         @(negedge clk_i);
         pin_or |= pin_o;
         both |= pin_o[0] & pin_o[1];
         wev |= cc_event_o;
         ovf_n += int'(overflow_o);
         w1 += int'(wave_o[1]);
         cmax = (count_o > cmax) ? count_o : cmax;
      end
   endtask
   task automatic wait_ovf();
      int k;
      for (k = 0; k < 2000 && overflow_o !== 1'b1; k++) @(negedge clk_i);
      if (k == 2000) begin
         n_errors++;
         final_report();
      end
   endtask
   task automatic wcmp(input logic [3:0] m, input count_t v);
      cmp_buf_i = v;
      cmp_wr_i = m;
      obs(1);
      cmp_wr_i = 4'h0;
      obs(1);
   endtask
   // Overflows in a 720-cycle window, a multiple of every period used
   task automatic meas(input wave_mode_t m, input logic [2:0] p, input logic h, input count_t e);
      wave_mode_i = m;
      presc_sel_i = p;
      hires_en_i = h;
      obs(100);
      obs(720);
      chk(16'(ovf_n), e);
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // ============================================================
   // Main sequence
   initial begin
      reset_i = 1'b1;
      {enable_i, ext_count_i, dir_event_en_i, period_wr_i, noise_cancel_en_i} = '0;
      {dti_en_i, pattern_en_i, pattern_wr_i, fault_clear_i, cmp_wr_i, capture_en_i} = '0;
      {event_i, pattern_buf_i, override_en_i, port_out_i, pin_invert_i, dt_wr_i} = '0;
      {presc_sel_i, dir_event_sel_i, capture_sel_i, period_buf_i, cmp_buf_i} = '0;
      {dt_ls_buf_i, dt_hs_buf_i, fault_event_mask_i} = '0;
      count_event_sel_i = 3'h5;
      hires_en_i = 1'b1;
      clk_src_i = CS_EVENT;
      wave_mode_i = WM_SINGLE;
      capture_mode_i = CAP_NONE;
      repeat (5) @(negedge clk_i);
      chk(count_o, 16'h0);
      chk(16'(pin_o), 16'h0);
      reset_i = 1'b0;
      enable_i = 1'b1;
      for (int s = 0; s < 2; s++) begin
         clk_src_i = s ? CS_EXT : CS_EVENT;
         obs(4);
         c0 = count_o;
         repeat (3) begin
            {event_i[5], ext_count_i} = 2'h3;
            obs(2);
            {event_i[5], ext_count_i} = 2'h0;
            obs(2);
         end
         chk(count_o - c0, 16'h3);
      end
      $display("done: count sources");
      enable_i = 1'b0;
      clk_src_i = CS_CLOCK;
      period_buf_i = 16'h9;
      period_wr_i = 1'b1;
      wcmp(4'h1, 16'h4);
      period_wr_i = 1'b0;
      wcmp(4'h2, 16'h3);
      wcmp(4'h8, 16'h7);
      obs(2);
      chk(cc_value_o[1], 16'h3);
      chk(cc_value_o[3], 16'h7);
      enable_i = 1'b1;
      meas(WM_SINGLE, 3'h0, 1'b1, 16'h48);
      chk(16'(w1), 16'hd8);
      chk(16'(wev[1]), 16'h1);
      meas(WM_FREQ, 3'h0, 1'b1, 16'h90);
      meas(WM_DUAL, 3'h0, 1'b1, 16'h28);
      meas(WM_SINGLE, 3'h1, 1'b1, 16'h24);
      meas(WM_SINGLE, 3'h3, 1'b1, 16'h9);
      meas(WM_SINGLE, 3'h0, 1'b0, 16'h12);
      hires_en_i = 1'b1;
      $display("done: waveforms");
      wait_ovf();
      period_buf_i = 16'h4;
      period_wr_i = 1'b1;
      obs(1);
      period_wr_i = 1'b0;
      obs(6);
      chk(16'(cmax > 16'h4), 16'h1);
      wait_ovf();
      obs(20);
      chk(cmax, 16'h4);
      dir_event_sel_i = 3'h2;
      dir_event_en_i = 1'b1;
      event_i[2] = 1'b1;
      obs(6);
      chk(16'(count_down_o), 16'h1);
      {dir_event_en_i, event_i[2]} = 2'h0;
      $display("done: buffering and direction");
      capture_sel_i[2] = 3'h3;
      capture_mode_i = CAP_INPUT;
      {capture_en_i, noise_cancel_en_i} = 5'h9;
      event_i[3] = 1'b1;
      obs(2);
      event_i[3] = 1'b0;
      obs(8);
      chk(16'(wev[2]), 16'h0);
      event_i[3] = 1'b1;
      obs(10);
      chk(16'(wev[2]), 16'h1);
      chk(16'(cc_value_o[2] <= 16'h4), 16'h1);
      capture_mode_i = CAP_FREQ;
      event_i[3] = 1'b0;
      obs(6);
      event_i[3] = 1'b1;
      obs(6);
      chk(count_o, 16'h1);
      chk(16'(wev[2]), 16'h1);
      {capture_en_i, event_i[3]} = 5'h0;
      $display("done: capture");
      wcmp(4'h1, 16'h3);
      {dt_ls_buf_i, dt_hs_buf_i, dt_wr_i} = 20'h01001;
      obs(1);
      dt_wr_i = 4'h0;
      {dti_en_i, port_out_i, pin_invert_i} = 17'h18080;
      obs(20);
      override_en_i = 8'h03;
      obs(40);
      chk(16'(pin_or), 16'h3);
      chk(16'(both), 16'h0);
      pin_invert_i = 8'h00;
      obs(10);
      chk(16'(pin_or), 16'h83);
      fault_event_mask_i = 8'h10;
      event_i[4] = 1'b1;
      obs(1);
      event_i[4] = 1'b0;
      obs(4);
      obs(10);
      chk(16'(fault_o), 16'h1);
      chk(16'(pin_or), 16'h80);
      fault_clear_i = 1'b1;
      obs(1);
      fault_clear_i = 1'b0;
      obs(2);
      chk(16'(fault_o), 16'h0);
      $display("done: dead time and fault");
      {pattern_buf_i, pattern_wr_i} = 9'h9;
      obs(1);
      {pattern_en_i, pattern_wr_i, override_en_i} = 10'h20c;
      obs(20);
      obs(40);
      chk(16'(pin_or), 16'h84);
      chk(16'(shoot), 16'h0);
      $display("done: pattern");
      final_report();
   end
endmodule // timer_with_waveform_extensions_tb
